// ===== rtl/modem_status_defines.svh
`ifndef MODEM_STATUS_DEFINES_SVH
`define MODEM_STATUS_DEFINES_SVH

// Register indices and byte addresses (byte address is four times the index)
`define MSR_INDEX 4'h2
`define MSR_ADDR 6'h08
`define CTRL_INDEX 4'h6
`define CTRL_ADDR 6'h18

// Control register fields
`define CTRL_LOCAL_TEST_BIT 0
`define CTRL_TEST_STOP_BIT 1

// Reset values
`define STATUS_RESET 8'h00
`define CTRL_RESET 2'h0

// Rate codes
`define RATE_300 2'h0
`define RATE_1200 2'h1
`define RATE_UNUSED 2'h2
`define RATE_2400 2'h3

// Least test startup time and its cycle count at 100 MHz
`define CLK_PERIOD_NS 10
`define TEST_STARTUP_NS 2000
`define TEST_STARTUP_CYCLES ((`TEST_STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/modem_status_pkg.sv
package modem_status_pkg;

  // Test mode sequencer states, Gray along idle, starting, active
  typedef enum logic [1:0]
  {
    TS_IDLE = 2'h0,
    TS_STARTING = 2'h1,
    TS_ACTIVE = 2'h3
  } test_state_e;

  // Register select from address decode
  typedef enum logic [1:0]
  {
    SEL_NONE = 2'h0,
    SEL_STATUS = 2'h1,
    SEL_CTRL = 2'h2
  } reg_sel_e;

  // Status register layout, bit 7 first
  typedef struct packed
  {
    logic err;
    logic tm;
    logic rm;
    logic dsr;
    logic [1:0] rate;
    logic received_line_signal_flag;
    logic cts;
  } modem_status_s;

  // State handed over by the modem core on the same clock
  typedef struct packed
  {
    logic data_mode;
    logic answer_set;
    logic call_end;
    logic handshake_done;
    logic rx_valid;
    logic tx_on;
    logic send_clamped;
    logic [1:0] rate;
    logic selftest_rx_error;
    logic test_startup_done;
  } modem_core_s;

endpackage : modem_status_pkg

// ===== rtl/modem_pin_sync.sv
module modem_pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);
  import modem_status_pkg::*;

  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  // Two flops per pin; no logic sits between the stages
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta <= pin_async;
      pin_sync <= meta;
    end
  end

endmodule : modem_pin_sync

// ===== rtl/test_mode_tracker.sv
module test_mode_tracker #(
  parameter int STARTUP_CYCLES = 200
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Requests and core progress
  input wire logic local_request,
  input wire logic remote_request,
  input wire logic startup_done,
  input wire logic test_stop,
  // Test mode entered
  output logic test_active
);
  import modem_status_pkg::*;

  test_state_e state; // Sequencer state
  test_state_e next_state;
  logic [11:0] cnt; // Startup time counter
  logic [11:0] next_cnt;
  logic want; // Any source asks for a test
  logic time_up; // Least startup time elapsed

  assign want = local_request | remote_request;
  assign time_up = (cnt >= 12'(STARTUP_CYCLES - 1));
  // Active only once fully entered
  assign test_active = (state == TS_ACTIVE);

  // Next state: enter only after startup time and core confirmation
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      TS_IDLE:
      begin
        next_cnt = 12'h000;
        // Local or remote activation both count
        if (want && !test_stop)
        begin
          next_state = TS_STARTING;
        end
      end
      TS_STARTING:
      begin
        if (test_stop || !want)
        begin
          next_state = TS_IDLE;
        end
        else if (time_up && startup_done)
        begin
          next_state = TS_ACTIVE;
        end
        else if (!time_up)
        begin
          next_cnt = cnt + 12'h001;
        end
      end
      TS_ACTIVE:
      begin
        // Leave when stopped or no longer asked for
        if (test_stop || !want)
        begin
          next_state = TS_IDLE;
        end
      end
      default:
      begin
        next_state = TS_IDLE;
      end
    endcase
  end

  // Register only
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= TS_IDLE;
      cnt <= 12'h000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

endmodule : test_mode_tracker

// ===== rtl/modem_status_register.sv
// Contract
// - Self-test error sets bit 7; read clears it
// - Test-mode bit set for local or remote test
// - Test-mode bit low until test fully entered
// - CTS needs handshake, transmitter on, send unclamped
// - CTS bit mirrors circuit CB
//
// Implementation choice: register access over Avalon-MM.
`include "modem_status_defines.svh"

module modem_status_register #(
  parameter int STARTUP_CYCLES = `TEST_STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave, byte addresses
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Modem core state, same clock
  input wire modem_status_pkg::modem_core_s core,
  // Line-side pins, asynchronous
  input wire logic ring_detect_pin,
  input wire logic remote_test_pin,
  // Status out
  output logic circuit_cb,
  output modem_status_pkg::modem_status_s status
);
  import modem_status_pkg::*;

  // Bus handshake
  logic ack; // Second cycle of a request
  logic next_ack;
  logic [31:0] next_readdata;
  reg_sel_e sel; // Decoded target
  logic status_read_done; // Host read of status completes
  logic ctrl_write_done; // Host write of control completes

  // Control register and status state
  logic [1:0] ctrl; // Test request and stop
  logic [1:0] next_ctrl;
  modem_status_s next_status;
  logic ring_seen; // Ring detected this call
  logic next_ring_seen;

  // Synchronised pins
  logic [1:0] pin_levels; // Both pins as one vector, remote test high
  logic ring_sync;
  logic remote_test_sync;

  // Test sequencer output
  logic test_active;

  // Address decode used for reads and writes
  function automatic reg_sel_e decode_addr(input logic [5:0] addr);
    if (addr == `MSR_ADDR)
    begin
      return SEL_STATUS;
    end
    else if (addr == `CTRL_ADDR)
    begin
      return SEL_CTRL;
    end
    else
    begin
      return SEL_NONE;
    end
  endfunction : decode_addr

  assign sel = decode_addr(avs_address);

  // Pins cross in through two flops each
  modem_pin_sync #(
    .WIDTH(2)
  ) modem_pin_sync_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_async({remote_test_pin, ring_detect_pin}),
    .pin_sync(pin_levels)
  );

  // Split the synchronised vector back into named levels
  assign ring_sync = pin_levels[0];
  assign remote_test_sync = pin_levels[1];

  // Test entry sequencing
  test_mode_tracker #(
    .STARTUP_CYCLES(STARTUP_CYCLES)
  ) test_mode_tracker_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .local_request(ctrl[`CTRL_LOCAL_TEST_BIT]),
    .remote_request(remote_test_sync),
    .startup_done(core.test_startup_done),
    .test_stop(ctrl[`CTRL_TEST_STOP_BIT]),
    .test_active(test_active)
  );

  // Every request waits exactly one cycle; the wait lets readdata
  // come from a flop at no cost in decode timing
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign status_read_done = avs_read & ack & (sel == SEL_STATUS);
  assign ctrl_write_done = avs_write & ack & (sel == SEL_CTRL);

  // CB is driven from the stored CTS bit, so both always agree
  assign circuit_cb = status.cts;

  // Bus next values
  always_comb
  begin
    next_ack = (avs_read | avs_write) & ~ack;
    next_readdata = avs_readdata;
    // Capture on the waiting cycle
    if (avs_read && !ack)
    begin
      if (sel == SEL_STATUS)
      begin
        next_readdata = {24'h000000, status};
      end
      else if (sel == SEL_CTRL)
      begin
        next_readdata = {30'h00000000, ctrl};
      end
      else
      begin
        // Unmapped reads return zero
        next_readdata = 32'h00000000;
      end
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // Control next value; status writes are ignored, read-only register
  always_comb
  begin
    next_ctrl = ctrl;
    if (ctrl_write_done && avs_byteenable[0])
    begin
      next_ctrl = avs_writedata[1:0];
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= `CTRL_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // Status next values
  always_comb
  begin
    next_status = status;
    // Error: a new error wins over the clearing read, so none is lost.
    // The host must discard the first read after starting a self-test.
    next_status.err = core.selftest_rx_error | (status.err & ~status_read_done);
    // Test mode only from the sequencer's active state
    next_status.tm = test_active;
    // Ring memory held for the call, cleared when it ends
    next_ring_seen = ring_sync | (ring_seen & ~core.call_end);
    next_status.rm = (ring_seen & core.data_mode & core.answer_set)
                   | (status.rm & ~core.call_end);
    next_status.dsr = core.data_mode;
    // Rate reported in data mode only; the unused code reads as 300
    if (core.data_mode && core.rate != `RATE_UNUSED)
    begin
      next_status.rate = core.rate;
    end
    else
    begin
      next_status.rate = `RATE_300;
    end
    next_status.received_line_signal_flag = core.handshake_done & core.rx_valid;
    // All three conditions, else clear
    next_status.cts = core.handshake_done & core.tx_on & ~core.send_clamped;
  end

  // Status registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= `STATUS_RESET;
      ring_seen <= 1'b0;
    end
    else
    begin
      status <= next_status;
      ring_seen <= next_ring_seen;
    end
  end

  // Checks
  default clocking dclk @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // A request waiting now
  sequence req_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  // A status read taken at this edge
  sequence status_read_taken;
    avs_read && !avs_waitrequest && sel == SEL_STATUS;
  endsequence

  // Request is answered one cycle later
  chk_bus_answer: assert property (req_waiting |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");

  // Read data show the status seen one cycle before
  chk_read_data: assert property (status_read_taken |-> avs_readdata[7:0] == $past(status))
    else $error("status read data mismatch");

  chk_err_read_clear: assert property (
    status_read_taken ##0 !core.selftest_rx_error |=> !status.err)
    else $error("error bit not cleared by read");

  chk_err_set_wins: assert property (
    core.selftest_rx_error |=> status.err)
    else $error("error bit missed a set");

  chk_tm_startup: assert property (
    $rose(status.tm) |-> $past(core.test_startup_done, 2))
    else $error("test mode shown before startup done");

  chk_tm_active: assert property (
    remote_test_sync && !ctrl[`CTRL_TEST_STOP_BIT] ##1 test_active |=> status.tm)
    else $error("test mode bit missing for active test");

  chk_cts_cond: assert property (
    status.cts |-> $past(core.handshake_done) && $past(core.tx_on) && !$past(core.send_clamped))
    else $error("CTS set without its conditions");

  chk_cb_mirror: assert property (
    $changed(status.cts) |-> $changed(circuit_cb) && circuit_cb == status.cts)
    else $error("CB does not follow CTS");

  // Rate field never shows the unused code
  chk_rate_code: assert property (status.rate != `RATE_UNUSED)
    else $error("unused rate code shown");

  // Outside data mode the field rests at the lowest rate
  chk_rate_idle: assert property (!status.dsr |-> status.rate == `RATE_300)
    else $error("rate code shown outside data mode");

  // Error flag holds until a status read completes
  chk_err_hold: assert property (
    status.err && !(avs_read && !avs_waitrequest && sel == SEL_STATUS) |=> status.err)
    else $error("error bit lost without a read");

  // Receive line flag needs handshake and valid data
  chk_rls_cond: assert property (
    status.received_line_signal_flag |-> $past(core.handshake_done) && $past(core.rx_valid))
    else $error("line signal flag set without its conditions");

  // Data set ready follows data mode
  chk_dsr_mode: assert property (core.data_mode |=> status.dsr)
    else $error("data set ready does not follow data mode");

  // Ring seen while answering in data mode
  sequence ring_answer;
    ring_seen && core.data_mode && core.answer_set;
  endsequence

  // Ring memory set once answered in data mode
  chk_rm_set: assert property (ring_answer |=> status.rm)
    else $error("ring memory not set");

  // End of call clears ring memory unless set again
  chk_rm_clear: assert property (
    core.call_end && !(ring_seen && core.data_mode && core.answer_set) |=> !status.rm)
    else $error("ring memory not cleared at call end");

  // Control write with low byte enabled lands one edge later
  chk_ctrl_write: assert property (
    avs_write && !avs_waitrequest && sel == SEL_CTRL && avs_byteenable[0]
    |=> ctrl == $past(avs_writedata[1:0]))
    else $error("control write not applied");

endmodule : modem_status_register

// ===== sim/host_cpu_model.sv
`include "modem_status_defines.svh"

module host_cpu_model (
  // Clock
  input wire logic sys_clk,
  // Avalon-MM master side
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    avs_address <= 6'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'hF;
  end

  // One bus cycle; waits as long as the slave stalls
  task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    // Released lines flip so stale values never look valid
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~wd;
  endtask : access

  // Throwaway read that flushes a stale error flag
  task automatic discard_error_read;
    logic [31:0] junk;
    access(1'b0, `MSR_ADDR, 32'h0, junk);
  endtask : discard_error_read
endmodule : host_cpu_model

// ===== sim/test_modem_status_register.sv
`include "modem_status_defines.svh"

module test_modem_status_register;
  timeunit 1ns;
  timeprecision 1ps;
  import modem_status_pkg::*;

  // Clock, reset and bus
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Core state and pins
  modem_core_s core = '0;
  logic ring_detect_pin = 1'b0;
  logic remote_test_pin = 1'b0;
  logic circuit_cb;
  modem_status_s status;
  // Score
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [1:0] rate_exp [4] = '{2'h0, 2'h1, 2'h0, 2'h3};

  always #5 sys_clk = ~sys_clk;

  // Short startup keeps the run brief
  modem_status_register #(.STARTUP_CYCLES(4)) modem_status_register_inst (.sys_clk(sys_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core(core),
    .ring_detect_pin(ring_detect_pin), .remote_test_pin(remote_test_pin),
    .circuit_cb(circuit_cb), .status(status));

  host_cpu_model host_cpu_model_inst (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // Compare and log
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Let registered and synchronised paths land
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic rd_status;
    host_cpu_model_inst.access(1'b0, `MSR_ADDR, 32'h0, rd);
  endtask : rd_status

  // Reset value, write to read-only, unmapped read
  task automatic t_reset;
    host_cpu_model_inst.access(1'b1, `MSR_ADDR, 32'hFF, rd);
    rd_status();
    check(rd, 32'h0);
    host_cpu_model_inst.access(1'b0, 6'h3C, 32'h0, rd);
    check(rd, 32'h0);
  endtask : t_reset

  // Error flag: stale flush, then set and clear on read
  task automatic t_error;
    @(posedge sys_clk);
    core.selftest_rx_error <= 1'b1;
    @(posedge sys_clk);
    core.selftest_rx_error <= 1'b0;
    settle(2);
    check(status.err, 1'b1);
    host_cpu_model_inst.discard_error_read();
    settle(1);
    check(status.err, 1'b0);
    @(posedge sys_clk);
    core.selftest_rx_error <= 1'b1;
    @(posedge sys_clk);
    core.selftest_rx_error <= 1'b0;
    rd_status();
    check(rd[7], 1'b1);
    rd_status();
    check(rd[7], 1'b0);
  endtask : t_error

  // All handshake, transmitter and clamp combinations
  task automatic t_cts;
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      @(posedge sys_clk);
      core.rx_valid <= 1'b1;
      {core.handshake_done, core.tx_on, core.send_clamped} <= c;
      settle(3);
      check(status.cts, c[2] & c[1] & ~c[0]);
      check(circuit_cb, c[2] & c[1] & ~c[0]);
      check(status.received_line_signal_flag, c[2]);
    end
  endtask : t_cts

  // Rate codes in and out of data mode
  task automatic t_rate;
    for (int r = 0; r < 4; r++)
    begin
      @(posedge sys_clk);
      core.data_mode <= 1'b1;
      core.rate <= 2'(r);
      settle(3);
      rd_status();
      check(rd[3:2], rate_exp[r]);
      check(rd[4], 1'b1);
    end
    @(posedge sys_clk);
    core.data_mode <= 1'b0;
    settle(3);
    check(status.rate, 2'h0);
  endtask : t_rate

  // Ring memory: needs answer in data mode, cleared at call end
  task automatic t_ring;
    @(posedge sys_clk);
    ring_detect_pin <= 1'b1;
    core.answer_set <= 1'b1;
    settle(4);
    check(status.rm, 1'b0);
    @(posedge sys_clk);
    ring_detect_pin <= 1'b0;
    core.data_mode <= 1'b1;
    settle(3);
    check(status.rm, 1'b1);
    check(status.dsr, 1'b1);
    @(posedge sys_clk);
    core.call_end <= 1'b1;
    core.data_mode <= 1'b0;
    core.answer_set <= 1'b0;
    settle(2);
    check(status.rm, 1'b0);
    @(posedge sys_clk);
    core.call_end <= 1'b0;
  endtask : t_ring

  // Local test, startup gating, stop, then remote test
  task automatic t_test;
    host_cpu_model_inst.access(1'b1, `CTRL_ADDR, 32'h1, rd);
    host_cpu_model_inst.access(1'b0, `CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h1);
    settle(20);
    check(status.tm, 1'b0);
    @(posedge sys_clk);
    core.test_startup_done <= 1'b1;
    settle(12);
    check(status.tm, 1'b1);
    host_cpu_model_inst.access(1'b1, `CTRL_ADDR, 32'h2, rd);
    settle(4);
    check(status.tm, 1'b0);
    host_cpu_model_inst.access(1'b1, `CTRL_ADDR, 32'h0, rd);
    remote_test_pin <= 1'b1;
    settle(20);
    check(status.tm, 1'b1);
    @(posedge sys_clk);
    remote_test_pin <= 1'b0;
    settle(8);
    check(status.tm, 1'b0);
  endtask : t_test

  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_error();
    t_cts();
    t_rate();
    t_ring();
    t_test();
    tally_and_finish();
  end

  // Hang guard, several times the expected run
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_modem_status_register
